/* File: design/dlog_pkg.sv */
package dlog_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_MULT        = 8'h00;
    localparam logic [7:0]  OFF_TICK_COUNT  = 8'h04;
    localparam logic [7:0]  OFF_INPUTS      = 8'h08;
    localparam logic [7:0]  OFF_START_SETUP = 8'h0c;
    localparam logic [7:0]  OFF_STORE_SETUP = 8'h10;
    localparam logic [7:0]  OFF_REQUESTED   = 8'h14;
    localparam logic [7:0]  OFF_OUTSTANDING = 8'h18;
    localparam logic [7:0]  OFF_RUN_CTRL    = 8'h1c;
    localparam logic [7:0]  OFF_OUT_DRIVE   = 8'h20;
    localparam logic [7:0]  OFF_OUT_ROUTE   = 8'h24;
    localparam logic [7:0]  OFF_TS_HOLD     = 8'h28;

    localparam int          SETUP_AND_BIT   = 31;
    localparam int          CODE_W          = 3;
    localparam int          LINES           = 4;
    localparam int          CHANNELS        = 3;
    localparam int          RUN_BIT         = 0;
    localparam int          TRIGGERED_BIT   = 1;
    localparam int          CONT_BIT        = 2;
    localparam int          WIDTH_SEL_HI    = 31;
    localparam int          WIDTH_SEL_LO    = 30;
    localparam int          MERGED_LINE     = 3;

    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

    localparam logic [2:0]  COND_NEVER      = 3'h0;
    localparam logic [2:0]  COND_RISE       = 3'h1;
    localparam logic [2:0]  COND_FALL       = 3'h2;
    localparam logic [2:0]  COND_CHANGE     = 3'h3;
    localparam logic [2:0]  COND_HIGH       = 3'h4;
    localparam logic [2:0]  COND_LOW        = 3'h5;

    localparam int          CLK_MHZ         = 125;
    localparam int          BASE_TICK_NS    = 30000;
    localparam int          BASE_TICK_CYC   = BASE_TICK_NS * CLK_MHZ / 1000;
    localparam int          PULSE_1MS_NS    = 1000000;
    localparam int          PULSE_200US_NS  = 200000;
    localparam int          PULSE_20US_NS   = 20000;
    localparam int          PULSE_5US_NS    = 5000;
    localparam int          PULSE_1MS_CYC   = PULSE_1MS_NS * CLK_MHZ / 1000;
    localparam int          PULSE_200US_CYC = PULSE_200US_NS * CLK_MHZ / 1000;
    localparam int          PULSE_20US_CYC  = PULSE_20US_NS * CLK_MHZ / 1000;
    localparam int          PULSE_5US_CYC   = PULSE_5US_NS * CLK_MHZ / 1000;
    localparam int          PULSE_W         = 17;

    localparam int          TS_MHZ          = 33;
    localparam int          TS_ACC_W        = 8;
endpackage : dlog_pkg

/* File: design/pulse_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch
    import dlog_pkg::*;
(
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    input  wire logic               fire_i,
    input  wire logic [PULSE_W-1:0] width_i,
    output var  logic               pulse_o
);
    logic [PULSE_W-1:0] remain;

    // Holds the output high for width_i cycles, retriggerable
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            remain  <= '0;
            pulse_o <= 1'b0;
        end
        else if (fire_i)
        begin
            remain  <= width_i;
            pulse_o <= 1'b1;
        end
        else if (remain > 1)
        begin
            remain <= remain - 1'b1;
        end
        else
        begin
            remain  <= '0;
            pulse_o <= 1'b0;
        end
    end
endmodule : pulse_stretch
`default_nettype wire

/* File: design/data_logging_trigger_io.sv */
// Contract
// [RULE1] Multiplier N read/write, sets tick period
// [RULE2] Tick counter advances every (N+1)*30us
// [RULE3] Counter write clears only when idle
// [RULE4] Input bits read 1 when pin low
// [RULE5] Start setup: four codes, AND/OR select
// [RULE6] Store setup: same layout, qualifies storage
// [RULE7] Codes never, rising, falling
// [RULE8] Codes change, high, low, always
// [RULE9] Requested sample count register
// [RULE10] Outstanding sample count read-only
// [RULE11] Run bit starts/stops, reads state
// [RULE12] Triggered flag read-only
// [RULE13] Continuous flag read-only, rest reserved
// [RULE14] Output bit 1 pulls pin low
// [RULE15] Routing bits 31:30 pick pulse width
// [RULE16] Routing bit 3 selects merged pulse
// [RULE17] Routing bits 2:0 select channel pulses
// [RULE18] Channel triggers ORed into merged pulse
// [RULE19] Merged adds input and logging triggers
// [RULE20] Capture-enabled channels load output latch
// [RULE21] Time stamp held on each trigger
// [RULE22] Host clears channel status after reading
// [RULE23] New start rearms trigger search
// [RULE24] No storage before trigger
// [RULE25] Store strobe aligned to sampling tick
// [RULE26] Outstanding loads, decrements, ends at zero
// [RULE27] Edges compare against previous sample
`timescale 1ns/1ps
`default_nettype none
module data_logging_trigger_io
    import dlog_pkg::*;
#(
    parameter int PULSE_1MS_COUNT   = PULSE_1MS_CYC,
    parameter int PULSE_200US_COUNT = PULSE_200US_CYC
)
(
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    input  wire logic [ADDR_W-1:0]   addr_i,
    input  wire logic [31:0]         wr_data_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output var  logic [31:0]         rd_data_o,
    input  wire logic [LINES-1:0]    input_line_i,
    output logic      [LINES-1:0]    output_line_o,
    output var  logic [LINES-1:0]    output_line_oe_o,
    input  wire logic [CHANNELS-1:0] enc_trigger_i,
    input  wire logic [CHANNELS-1:0] capture_enable_i,
    input  wire logic                input_edge_trigger_i,
    output logic                     merged_trigger_o,
    output logic [CHANNELS-1:0]      latch_load_o,
    output logic                     log_store_o,
    output var  logic [31:0]         time_stamp_hold_o
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_STORE = 3'b100
    } acq_e;
    acq_e               state;
    logic [31:0]        multiplier;
    logic [31:0]        tick_count;
    logic [31:0]        start_setup;
    logic [31:0]        store_setup;
    logic [31:0]        requested;
    logic [31:0]        outstanding;
    logic [LINES-1:0]   drive;
    logic [31:0]        routing;
    logic               continuous;
    logic [15:0]        base_count;
    logic               base_tick;
    logic [31:0]        mult_count;
    logic               sample_tick;
    logic [LINES-1:0]   line_meta;
    logic [LINES-1:0]   line_level;
    logic [LINES-1:0]   line_prev;
    logic [TS_ACC_W-1:0] ts_phase;
    logic [31:0]        time_stamp_counter;
    logic               running;
    logic               start_met;
    logic               store_met;
    logic               start_wr;
    logic               stop_wr;
    logic               count_clear;
    logic [PULSE_W-1:0] pulse_width;
    logic [LINES-1:0]   pulse_fire;
    logic [LINES-1:0]   pulse_line;
    // Per-line condition code evaluation
    function automatic logic cond_hit(input logic [2:0] code, input logic cur,
                                      input logic prev);
        logic hit;
        case (code)
            COND_NEVER:  hit = 1'b0;                   // RULE7
            COND_RISE:   hit = cur & ~prev;            // RULE7
            COND_FALL:   hit = ~cur & prev;            // RULE7
            COND_CHANGE: hit = cur ^ prev;             // RULE8
            COND_HIGH:   hit = cur;                    // RULE8
            COND_LOW:    hit = ~cur;                   // RULE8
            default:     hit = 1'b1;                   // RULE8
        endcase
        return hit;
    endfunction : cond_hit
    // AND or OR combination over all lines
    function automatic logic setup_hit(input logic [31:0] setup,
                                       input logic [LINES-1:0] cur,
                                       input logic [LINES-1:0] prev);
        logic [LINES-1:0] hits;
        hits = '0;
        for (int k = 0; k < LINES; k++)
        begin
            hits[k] = cond_hit(setup[k*CODE_W +: CODE_W], cur[k], prev[k]);
        end
        return setup[SETUP_AND_BIT] ? &hits : |hits;
    endfunction : setup_hit
    assign running     = (state != ST_IDLE);
    assign start_wr    = wr_i && (addr_i == OFF_RUN_CTRL) && wr_data_i[RUN_BIT];
    assign stop_wr     = wr_i && (addr_i == OFF_RUN_CTRL) && !wr_data_i[RUN_BIT];
    assign count_clear = wr_i && (addr_i == OFF_TICK_COUNT) && !running;
    assign start_met   = setup_hit(start_setup, line_level, line_prev);   // RULE5
    assign store_met   = setup_hit(store_setup, line_level, line_prev);   // RULE6
    assign log_store_o = sample_tick && (state == ST_STORE) && store_met; // RULE24 RULE25
    // Two-stage synchroniser for the input pins
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            line_meta  <= {LINES{1'b1}};
            line_level <= {LINES{1'b1}};
        end
        else
        begin
            line_meta  <= input_line_i;
            line_level <= line_meta;
        end
    end
    // Level at the previous sampling point
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            line_prev <= {LINES{1'b1}};
        else if (sample_tick)
            line_prev <= line_level;                   // RULE27
    end
    // 30 us base tick and (N+1) multiplier
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            base_count  <= '0;
            base_tick   <= 1'b0;
            mult_count  <= '0;
            sample_tick <= 1'b0;
        end
        else
        begin
            base_tick   <= (base_count == 16'(BASE_TICK_CYC - 1));
            base_count  <= (base_count == 16'(BASE_TICK_CYC - 1)) ? '0 : base_count + 1'b1;
            sample_tick <= base_tick && (mult_count >= multiplier);   // RULE1
            if (base_tick)
                mult_count <= (mult_count >= multiplier) ? '0 : mult_count + 1'b1;
        end
    end
    // Sampling counter
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || count_clear)
            tick_count <= RESET_WORD;                  // RULE3
        else if (sample_tick)
            tick_count <= tick_count + 1'b1;           // RULE2
    end
    // Software-written configuration
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            multiplier  <= RESET_WORD;
            start_setup <= RESET_WORD;
            store_setup <= RESET_WORD;
            requested   <= RESET_WORD;
            drive       <= '0;
            routing     <= RESET_WORD;
        end
        else if (wr_i)
        begin
            case (addr_i)
                OFF_MULT:        multiplier  <= wr_data_i;                  // RULE1
                OFF_START_SETUP: start_setup <= wr_data_i & 32'h8000_0fff;  // RULE5
                OFF_STORE_SETUP: store_setup <= wr_data_i & 32'h8000_0fff;  // RULE6
                OFF_REQUESTED:   requested   <= wr_data_i;                  // RULE9
                OFF_OUT_DRIVE:   drive       <= wr_data_i[LINES-1:0];
                OFF_OUT_ROUTE:   routing     <= wr_data_i & 32'hc000_000f;
                default:         ;
            endcase
        end
    end
    // Acquisition sequencing
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state       <= ST_IDLE;
            outstanding <= RESET_WORD;
            continuous  <= 1'b0;
        end
        else if (start_wr)
        begin
            state       <= ST_ARMED;                   // RULE23
            outstanding <= requested;                  // RULE26
            continuous  <= (requested == RESET_WORD);
        end
        else if (stop_wr)
        begin
            state <= ST_IDLE;                          // RULE11
        end
        else
        begin
            case (state)
                ST_IDLE:
                    state <= ST_IDLE;
                ST_ARMED:
                    if (sample_tick && start_met)
                        state <= ST_STORE;
                ST_STORE:
                    if (log_store_o && !continuous)
                    begin
                        outstanding <= outstanding - 1'b1;  // RULE26
                        if (outstanding == 32'h0000_0001)
                            state <= ST_IDLE;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
    // Triggered flag stays until the next start; a stop in the same cycle wins
    logic triggered;
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || start_wr)
            triggered <= 1'b0;                         // RULE23
        else if (state == ST_ARMED && sample_tick && start_met && !stop_wr)
            triggered <= 1'b1;                         // RULE12
    end
    // Merged capture pulse and latch loads
    assign merged_trigger_o = |enc_trigger_i | input_edge_trigger_i
                              | log_store_o;           // RULE18 RULE19
    assign latch_load_o     = {CHANNELS{merged_trigger_o}} & capture_enable_i;  // RULE20
    // 33 MHz time stamp from a fractional divider
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            ts_phase           <= '0;
            time_stamp_counter <= RESET_WORD;
        end
        else if (ts_phase + TS_ACC_W'(TS_MHZ) >= TS_ACC_W'(CLK_MHZ))
        begin
            ts_phase           <= ts_phase + TS_ACC_W'(TS_MHZ) - TS_ACC_W'(CLK_MHZ);
            time_stamp_counter <= time_stamp_counter + 1'b1;
        end
        else
        begin
            ts_phase <= ts_phase + TS_ACC_W'(TS_MHZ);
        end
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            time_stamp_hold_o <= RESET_WORD;
        else if (merged_trigger_o)
            time_stamp_hold_o <= time_stamp_counter;   // RULE21
    end
    // Trigger pulse width select
    always_comb
    begin
        case (routing[WIDTH_SEL_HI:WIDTH_SEL_LO])      // RULE15
            2'b00:   pulse_width = PULSE_W'(PULSE_1MS_COUNT);
            2'b01:   pulse_width = PULSE_W'(PULSE_200US_COUNT);
            2'b10:   pulse_width = PULSE_W'(PULSE_20US_CYC);
            default: pulse_width = PULSE_W'(PULSE_5US_CYC);
        endcase
    end
    assign pulse_fire = {merged_trigger_o, enc_trigger_i};
    // Open-drain output lines
    genvar g;
    generate
        for (g = 0; g < LINES; g++)
        begin : g_line
            pulse_stretch u_stretch (
                .clk_sys_i (clk_sys_i),
                .reset_i   (reset_i),
                .fire_i    (pulse_fire[g]),
                .width_i   (pulse_width),
                .pulse_o   (pulse_line[g])
            );
            always_ff @(posedge clk_sys_i)
            begin
                if (reset_i)
                    output_line_oe_o[g] <= 1'b0;
                else
                    output_line_oe_o[g] <= routing[g] ? pulse_line[g]
                                                      : drive[g];  // RULE14 RULE16 RULE17
            end
        end
    endgenerate
    assign output_line_o = '0;
    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            rd_data_o <= RESET_WORD;
        else if (rd_i)
        begin
            case (addr_i)
                OFF_MULT:        rd_data_o <= multiplier;
                OFF_TICK_COUNT:  rd_data_o <= tick_count;
                OFF_INPUTS:      rd_data_o <= {28'h0000000, ~line_level};  // RULE4
                OFF_START_SETUP: rd_data_o <= start_setup;
                OFF_STORE_SETUP: rd_data_o <= store_setup;
                OFF_REQUESTED:   rd_data_o <= requested;
                OFF_OUTSTANDING: rd_data_o <= outstanding;                 // RULE10
                OFF_RUN_CTRL:    rd_data_o <= {29'h0, running && continuous,
                                               triggered, running};        // RULE11 RULE13
                OFF_OUT_DRIVE:   rd_data_o <= {28'h0000000, drive};
                OFF_OUT_ROUTE:   rd_data_o <= routing;
                OFF_TS_HOLD:     rd_data_o <= time_stamp_hold_o;
                default:         rd_data_o <= RESET_WORD;
            endcase
        end
    end
    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_clear_idle: // RULE3
        assert property (count_clear |=> tick_count == 32'h0)
        else $error("tick counter not cleared while idle");
    a_clear_busy: // RULE3
        assert property (wr_i && addr_i == OFF_TICK_COUNT && running && !sample_tick
                         |=> tick_count == $past(tick_count))
        else $error("tick counter cleared while running");
    a_tick_advance: // RULE2
        assert property (sample_tick && !count_clear
                         |=> tick_count == $past(tick_count) + 32'h1)
        else $error("tick counter did not advance");
    a_start_rearm: // RULE23
        assert property (start_wr |=> !triggered && state == ST_ARMED)
        else $error("start did not rearm trigger");
    a_store_after: // RULE24
        assert property (log_store_o |-> triggered && sample_tick)
        else $error("store before trigger or off tick");
    a_count_down: // RULE26
        assert property (log_store_o && !continuous && !start_wr && !stop_wr
                         |=> outstanding == $past(outstanding) - 32'h1)
        else $error("outstanding not decremented");
    a_end_zero: // RULE26
        assert property (running && !continuous && outstanding == 32'h1 && log_store_o
                         && !start_wr |=> !running)
        else $error("acquisition did not end at zero");
    a_merge_or: // RULE19
        assert property ((|enc_trigger_i || input_edge_trigger_i) |-> merged_trigger_o)
        else $error("trigger missing from merged pulse");
    a_ts_hold: // RULE21
        assert property (merged_trigger_o |=> time_stamp_hold_o == $past(time_stamp_counter))
        else $error("time stamp not held");
endmodule : data_logging_trigger_io
`default_nettype wire

/* File: verification/ext_lines.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_lines
(
    input  wire logic [3:0] pull_low_i,
    input  wire logic [3:0] oe_i,
    input  wire logic [3:0] data_i,
    output var  logic [3:0] in_pin_o,
    output var  logic [3:0] out_pin_o
);
    // Open inputs rest high through the pull-up
    assign in_pin_o = ~pull_low_i;
    // Transistor on drives the data level, off leaves the pull-up
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            out_pin_o[i] = oe_i[i] ? data_i[i] : 1'b1;
        end
    end
endmodule : ext_lines
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dlog_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_s;
    logic        clk_sys_i;
    logic        reset_i;
    logic        wr_i;
    logic        rd_i;
    logic        in_trig;
    logic [7:0]  addr_i;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] tsh;
    logic [31:0] v;
    logic [31:0] ts0;
    logic [3:0]  low_cmd;
    logic [3:0]  pins;
    logic [3:0]  oe;
    logic [3:0]  odat;
    logic [3:0]  opin;
    logic [2:0]  enc;
    logic [2:0]  cap;
    logic [2:0]  lload;
    logic        merged;
    logic        store;
    int          n_mismatch;
    int          compares;
    int          t;
    int          c0;
    int          c3;
    row_s        rows [7];

    data_logging_trigger_io #(.PULSE_1MS_COUNT(40), .PULSE_200US_COUNT(20)) uut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wdat),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rdat), .input_line_i(pins),
        .output_line_o(odat), .output_line_oe_o(oe), .enc_trigger_i(enc),
        .capture_enable_i(cap), .input_edge_trigger_i(in_trig),
        .merged_trigger_o(merged), .latch_load_o(lload), .log_store_o(store),
        .time_stamp_hold_o(tsh));
    ext_lines far (.pull_low_i(low_cmd), .oe_i(oe), .data_i(odat), .in_pin_o(pins),
        .out_pin_o(opin));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdat   <= d;
        wr_i   <= 1'b1;
        @(posedge clk_sys_i);
        wr_i   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1 d = rdat;
    endtask : rd

    // Counts edges until the store strobe shows, giving up at lim
    task automatic wait_store(input int lim, output int n);
        n = 0;
        while (store !== 1'b1 && n < lim)
        begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        if (n >= lim)
        begin
            chk("store timeout", 32'h1, 32'h0);
            conclude();
        end
    endtask : wait_store

    initial
    begin
        rows = '{'{OFF_MULT, 32'hffffffff, 32'hffffffff},
                 '{OFF_START_SETUP, 32'hffffffff, 32'h80000fff},
                 '{OFF_STORE_SETUP, 32'hffffffff, 32'h80000fff},
                 '{OFF_REQUESTED, 32'h12345678, 32'h12345678},
                 '{OFF_OUTSTANDING, 32'hffffffff, 32'h00000000},
                 '{OFF_OUT_ROUTE, 32'hffffffff, 32'hc000000f},
                 '{8'h3c, 32'hffffffff, 32'h00000000}};
        {reset_i, wr_i, rd_i, in_trig} = 4'h8;
        addr_i = 8'h00;
        wdat = 32'h0;
        low_cmd = 4'h0;
        enc = 3'h0;
        cap = 3'h0;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        // Reset values of the whole map
        for (int a = 0; a <= 8'h28; a += 4)
        begin
            rd(8'(a), v);
            chk("reset value", 32'h0, v);
        end
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, v);
            chk("register row", rows[i].e, v);
        end
        wr(OFF_OUT_ROUTE, 32'h0);
        low_cmd <= 4'h5;
        repeat (4) @(posedge clk_sys_i);
        rd(OFF_INPUTS, v);
        chk("input levels", 32'h5, v);
        wr(OFF_OUT_DRIVE, 32'h9);
        repeat (3) @(posedge clk_sys_i);
        chk("drive oe", 32'h9, 32'(oe));
        chk("drive pins", 32'h6, 32'(opin));
        wr(OFF_OUT_DRIVE, 32'h0);
        // Routed trigger pulses, two widths
        cap <= 3'b101;
        for (int s = 0; s < 2; s++)
        begin
            wr(OFF_OUT_ROUTE, {s[0] ? 2'b01 : 2'b00, 30'h9});
            @(posedge clk_sys_i);
            enc <= 3'b001;
            #1 chk("merged", 32'h1, 32'(merged));
            chk("latch load", 32'h5, 32'(lload));
            @(posedge clk_sys_i);
            enc <= 3'b000;
            {c0, c3} = 0;
            repeat (100)
            begin
                @(posedge clk_sys_i);
                #1 c0 += int'(oe[0] === 1'b1);
                c3 += int'(oe[3] === 1'b1);
            end
            chk("width line0", s ? 32'd20 : 32'd40, 32'(c0));
            chk("width line3", s ? 32'd20 : 32'd40, 32'(c3));
        end
        @(posedge clk_sys_i);
        in_trig <= 1'b1;
        #1 chk("input trigger", 32'h1, 32'(merged));
        @(posedge clk_sys_i);
        in_trig <= 1'b0;
        // Triggered acquisition: rise on line 0, always store, two samples, N=1
        wr(OFF_MULT, 32'h1);
        wr(OFF_REQUESTED, 32'h2);
        wr(OFF_START_SETUP, 32'h1);
        wr(OFF_STORE_SETUP, 32'h6);
        low_cmd <= 4'h1;
        wr(OFF_RUN_CTRL, 32'h1);
        rd(OFF_RUN_CTRL, v);
        chk("running", 32'h1, v);
        c0 = 0;
        repeat (8000)
        begin
            @(posedge clk_sys_i);
            #1 c0 += int'(store === 1'b1);
        end
        chk("early stores", 32'h0, 32'(c0));
        rd(OFF_RUN_CTRL, v);
        chk("not triggered", 32'h1, v);
        wr(OFF_TICK_COUNT, 32'h0);
        rd(OFF_TICK_COUNT, v);
        chk("count kept", 32'h1, 32'(v != 32'h0));
        low_cmd <= 4'h0;
        wait_store(20000, t);
        chk("store merged", 32'h1, 32'(merged));
        ts0 = tsh;
        @(posedge clk_sys_i);
        #1 chk("stamp held", 32'h1, 32'(tsh !== ts0));
        ts0 = tsh;
        wait_store(20000, t);
        chk("store gap", 32'(BASE_TICK_CYC * 2 - 1), 32'(t));
        repeat (3) @(posedge clk_sys_i);
        rd(OFF_TS_HOLD, v);
        chk("stamp read", ts0 + 32'(TS_MHZ * BASE_TICK_CYC * 2 / CLK_MHZ), v);
        rd(OFF_OUTSTANDING, v);
        chk("outstanding", 32'h0, v);
        rd(OFF_RUN_CTRL, v);
        chk("ended", 32'h2, v);
        wr(OFF_TICK_COUNT, 32'h0);
        rd(OFF_TICK_COUNT, v);
        chk("count cleared", 32'h0, v);
        // Continuous run rearms the trigger search
        wr(OFF_REQUESTED, 32'h0);
        wr(OFF_RUN_CTRL, 32'h1);
        rd(OFF_RUN_CTRL, v);
        chk("continuous", 32'h5, v);
        wr(OFF_RUN_CTRL, 32'h0);
        rd(OFF_RUN_CTRL, v);
        chk("stopped", 32'h0, v);
        // Every code on a static pin, high then low
        wr(OFF_MULT, 32'h0);
        wr(OFF_REQUESTED, 32'h1);
        for (int p = 0; p < 2; p++)
        begin
            low_cmd <= 4'(p);
            for (int c = 0; c < 8; c++)
            begin
                wr(OFF_START_SETUP, 32'(c));
                wr(OFF_RUN_CTRL, 32'h1);
                repeat (3760) @(posedge clk_sys_i);
                rd(OFF_RUN_CTRL, v);
                chk("code", 32'((p ? 8'he0 : 8'hd0) >> c) & 32'h1, 32'(v[1]));
                wr(OFF_RUN_CTRL, 32'h0);
            end
        end
        conclude();
    end
endmodule : tb
`default_nettype wire
